//--- uic_pkg.sv
// package: register map, field layout and types for the serial port irq clear and id bank
// Functional notes
// - writing one to clear bit 9 clears pending break error interrupt; zero no effect
// - writing one to parity clear bit clears pending parity error interrupt; zero no effect
// - writing one to framing clear bit clears pending framing error interrupt; zero no effect
// - writing one to bit 6 clears receive time-out interrupt; reads zero
// - writing one to bit 5 clears transmit interrupt; zero no effect; resets zero
// - writing one to bit 4 clears receive interrupt; zero no effect; resets zero
// - clear register bits 3:0 are read-only reserved; software preserves them
// - identification registers are read-only, hard-coded; writes never alter them
// - each identification register holds one identity byte in 7:0, upper bits zero
// - identification registers 4..7 at 0xFD0..0xFDC, registers 0 and 1 at 0xFE0, 0xFE4
// - clear removes raw and masked status; clear register sits at offset 0x044
package uic_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_STATUS = 12'h03C;
  localparam logic [11:0] OFS_MASKED = 12'h040;
  localparam logic [11:0] OFS_ICLEAR = 12'h044;
  localparam logic [11:0] OFS_ENABLE = 12'h038;
  localparam logic [11:0] OFS_ID4 = 12'hFD0;
  localparam logic [11:0] OFS_ID5 = 12'hFD4;
  localparam logic [11:0] OFS_ID6 = 12'hFD8;
  localparam logic [11:0] OFS_ID7 = 12'hFDC;
  localparam logic [11:0] OFS_ID0 = 12'hFE0;
  localparam logic [11:0] OFS_ID1 = 12'hFE4;
  // six event bits occupy register bits 9:4
  localparam int EV_LSB = 4;
  localparam int EV_N = 6;
  localparam int BIT_RX = 4;
  localparam int BIT_TX = 5;
  localparam int BIT_RT = 6;
  localparam int BIT_FE = 7;
  localparam int BIT_PE = 8;
  localparam int BIT_BE = 9;
  localparam logic [5:0] EV_RESET = 6'h00;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  typedef struct packed {
    logic [5:0] raw;
    logic [5:0] enable;
    logic ack;
    logic [31:0] rdata;
  } uic_state_type;

  typedef struct packed {
    logic [ADDR_W-1:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
    logic cyc;
    logic stb;
  } uic_wb_req_type;
endpackage

//--- uic_regs.sv
// module: wishbone register bank with irq clear bits, enables and identity bytes
`timescale 1ns/10ps
module uic_regs
  import uic_pkg::*;
#(
  // identity bytes: arbitrary neutral values
  parameter logic [7:0] ID_BYTE0 = 8'hA5,
  parameter logic [7:0] ID_BYTE1 = 8'h5A,
  parameter logic [7:0] ID_BYTE4 = 8'h3C,
  parameter logic [7:0] ID_BYTE5 = 8'hC3,
  parameter logic [7:0] ID_BYTE6 = 8'h69,
  parameter logic [7:0] ID_BYTE7 = 8'h96
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // event pulses from receive and transmit logic, bit order rx,tx,rt,fe,pe,be
  input wire logic [EV_N-1:0] event_i,
  // status and interrupt
  output logic [EV_N-1:0] raw_status_o,
  output logic [EV_N-1:0] masked_status_o,
  output logic irq_o
);

  uic_state_type s_r;
  uic_state_type s_nxt;
  uic_wb_req_type req;
  logic access;
  logic wr_lane1;
  logic wr_lane0;

  assign req = '{adr: wb_adr_i, dat: wb_dat_i, sel: wb_sel_i, we: wb_we_i,
                 cyc: wb_cyc_i, stb: wb_stb_i};
  // one access per request: ack drops the cycle after it is given
  assign access = req.cyc && req.stb && !s_r.ack;
  assign wr_lane0 = access && req.we && req.sel[0];
  assign wr_lane1 = access && req.we && req.sel[1];

  function automatic logic [31:0] id_word(input logic [7:0] b);
    id_word = {24'h00_0000, b};
  endfunction

  function automatic logic [31:0] read_mux(input logic [ADDR_W-1:0] a,
                                           input logic [5:0] raw,
                                           input logic [5:0] en);
    case ({a[ADDR_W-1:2], 2'b00})
      OFS_STATUS: read_mux = {22'h00_0000, raw, 4'h0};
      OFS_MASKED: read_mux = {22'h00_0000, raw & en, 4'h0};
      OFS_ENABLE: read_mux = {22'h00_0000, en, 4'h0};
      OFS_ICLEAR: read_mux = ZERO_WORD;
      OFS_ID0: read_mux = id_word(ID_BYTE0);
      OFS_ID1: read_mux = id_word(ID_BYTE1);
      OFS_ID4: read_mux = id_word(ID_BYTE4);
      OFS_ID5: read_mux = id_word(ID_BYTE5);
      OFS_ID6: read_mux = id_word(ID_BYTE6);
      OFS_ID7: read_mux = id_word(ID_BYTE7);
      default: read_mux = ZERO_WORD;
    endcase
  endfunction

  always_comb begin
    logic [9:0] wbits;
    logic [5:0] clr;
    wbits = {req.dat[9:8] & {2{wr_lane1}}, req.dat[7:0] & {8{wr_lane0}}};
    clr = '0;
    s_nxt = s_r;
    s_nxt.ack = access;
    // clear register decode at 0x044, both low lanes needed
    if (wr_lane0 && wr_lane1 && req.adr[ADDR_W-1:2] == OFS_ICLEAR[ADDR_W-1:2]) begin
      // reserved bits 3:0 never reach the status bits
      clr = wbits[9:EV_LSB];
    end
    // event set wins over same-cycle clear
    s_nxt.raw = (s_r.raw & ~clr) | event_i;
    if (wr_lane0 && wr_lane1 && req.adr[ADDR_W-1:2] == OFS_ENABLE[ADDR_W-1:2]) begin
      s_nxt.enable = req.dat[9:EV_LSB];
    end
    if (access && !req.we) begin
      s_nxt.rdata = read_mux(req.adr, s_r.raw, s_r.enable);
    end
    if (rst_i) begin
      s_nxt = '0;
      s_nxt.raw = EV_RESET;
      s_nxt.enable = EV_RESET;
    end
  end

  always_ff @(posedge clk_i) begin
    s_r <= s_nxt;
  end

  assign wb_ack_o = s_r.ack;
  assign wb_dat_o = s_r.rdata;
  assign raw_status_o = s_r.raw;
  assign masked_status_o = s_r.raw & s_r.enable;
  assign irq_o = |(s_r.raw & s_r.enable);

  logic clr_wr;
  assign clr_wr = wr_lane0 && wr_lane1 && req.adr[ADDR_W-1:2] == OFS_ICLEAR[ADDR_W-1:2];

  property p_break_clear;
    @(posedge clk_i) disable iff (rst_i)
      clr_wr && req.dat[BIT_BE] && !event_i[5] |=> !raw_status_o[5];
  endproperty
  a_break_clear: assert property (p_break_clear) else $error("break clear failed");

  property p_parity_clear;
    @(posedge clk_i) disable iff (rst_i)
      clr_wr && req.dat[BIT_PE] && !event_i[4] |=> !raw_status_o[4];
  endproperty
  a_parity_clear: assert property (p_parity_clear) else $error("parity clear failed");

  property p_frame_clear;
    @(posedge clk_i) disable iff (rst_i)
      clr_wr && req.dat[BIT_FE] && !event_i[3] |=> !raw_status_o[3];
  endproperty
  a_frame_clear: assert property (p_frame_clear) else $error("framing clear failed");

  property p_rt_clear;
    @(posedge clk_i) disable iff (rst_i)
      clr_wr && req.dat[BIT_RT] && !event_i[2] |=> !raw_status_o[2];
  endproperty
  a_rt_clear: assert property (p_rt_clear) else $error("timeout clear failed");

  property p_tx_zero;
    @(posedge clk_i) disable iff (rst_i)
      clr_wr && !req.dat[BIT_TX] && raw_status_o[1] |=> raw_status_o[1];
  endproperty
  a_tx_zero: assert property (p_tx_zero) else $error("zero write cleared tx");

  property p_rx_clear;
    @(posedge clk_i) disable iff (rst_i)
      clr_wr && req.dat[BIT_RX] && !event_i[0] |=> !raw_status_o[0];
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("rx clear failed");

  property p_set_wins;
    @(posedge clk_i) disable iff (rst_i)
      event_i[0] |=> raw_status_o[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost");

  property p_id0_read;
    @(posedge clk_i) disable iff (rst_i)
      access && !req.we && req.adr == OFS_ID0 |=> wb_ack_o && wb_dat_o == {24'h0, ID_BYTE0};
  endproperty
  a_id0_read: assert property (p_id0_read) else $error("id0 read wrong");

  property p_id7_read;
    @(posedge clk_i) disable iff (rst_i)
      access && !req.we && req.adr == OFS_ID7 |=> wb_dat_o == {24'h0, ID_BYTE7};
  endproperty
  a_id7_read: assert property (p_id7_read) else $error("id7 read wrong");

  property p_irq_level;
    @(posedge clk_i) disable iff (rst_i)
      irq_o == |masked_status_o;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq mismatch");

  property p_ack_drop;
    @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack held");

  property p_tx_clear;
    @(posedge clk_i) disable iff (rst_i)
      clr_wr && req.dat[BIT_TX] && !event_i[1]
      |=> !raw_status_o[1];
  endproperty
  a_tx_clear: assert property (p_tx_clear) else $error("tx clear failed");

  property p_be_zero;
    @(posedge clk_i) disable iff (rst_i)
      clr_wr && !req.dat[BIT_BE] && raw_status_o[5]
      |=> raw_status_o[5];
  endproperty
  a_be_zero: assert property (p_be_zero) else $error("zero write cleared break");

  property p_pe_zero;
    @(posedge clk_i) disable iff (rst_i)
      clr_wr && !req.dat[BIT_PE] && raw_status_o[4]
      |=> raw_status_o[4];
  endproperty
  a_pe_zero: assert property (p_pe_zero) else $error("zero write cleared parity");

  property p_fe_zero;
    @(posedge clk_i) disable iff (rst_i)
      clr_wr && !req.dat[BIT_FE] && raw_status_o[3]
      |=> raw_status_o[3];
  endproperty
  a_fe_zero: assert property (p_fe_zero) else $error("zero write cleared framing");

  property p_rt_zero;
    @(posedge clk_i) disable iff (rst_i)
      clr_wr && !req.dat[BIT_RT] && raw_status_o[2]
      |=> raw_status_o[2];
  endproperty
  a_rt_zero: assert property (p_rt_zero) else $error("zero write cleared timeout");

  property p_rx_zero;
    @(posedge clk_i) disable iff (rst_i)
      clr_wr && !req.dat[BIT_RX] && raw_status_o[0]
      |=> raw_status_o[0];
  endproperty
  a_rx_zero: assert property (p_rx_zero) else $error("zero write cleared rx");

  property p_id1_read;
    @(posedge clk_i) disable iff (rst_i)
      access && !req.we && req.adr == OFS_ID1
      |=> wb_dat_o == {24'h0, ID_BYTE1};
  endproperty
  a_id1_read: assert property (p_id1_read) else $error("id1 read wrong");

  property p_id4_read;
    @(posedge clk_i) disable iff (rst_i)
      access && !req.we && req.adr == OFS_ID4
      |=> wb_dat_o == {24'h0, ID_BYTE4};
  endproperty
  a_id4_read: assert property (p_id4_read) else $error("id4 read wrong");

  property p_id5_read;
    @(posedge clk_i) disable iff (rst_i)
      access && !req.we && req.adr == OFS_ID5
      |=> wb_dat_o == {24'h0, ID_BYTE5};
  endproperty
  a_id5_read: assert property (p_id5_read) else $error("id5 read wrong");

  property p_id6_read;
    @(posedge clk_i) disable iff (rst_i)
      access && !req.we && req.adr == OFS_ID6
      |=> wb_dat_o == {24'h0, ID_BYTE6};
  endproperty
  a_id6_read: assert property (p_id6_read) else $error("id6 read wrong");

  property p_iclear_read;
    @(posedge clk_i) disable iff (rst_i)
      access && !req.we && req.adr == OFS_ICLEAR
      |=> wb_dat_o == ZERO_WORD;
  endproperty
  a_iclear_read: assert property (p_iclear_read) else $error("clear read not zero");

  property p_reserved_low;
    @(posedge clk_i) disable iff (rst_i)
      access && !req.we && req.adr < OFS_ID4
      |=> wb_dat_o[3:0] == 4'h0;
  endproperty
  a_reserved_low: assert property (p_reserved_low) else $error("reserved bits set");

  property p_enable_write;
    @(posedge clk_i) disable iff (rst_i)
      wr_lane0 && wr_lane1 && req.adr == OFS_ENABLE
      |=> irq_o == |(raw_status_o & $past(wb_dat_i[9:4]));
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable write lost");

  property p_id_write;
    @(posedge clk_i) disable iff (rst_i)
      access && req.we && req.adr >= OFS_ID4
      |=> $stable(wb_dat_o);
  endproperty
  a_id_write: assert property (p_id_write) else $error("id write changed data");

  property p_ack_answer;
    @(posedge clk_i) disable iff (rst_i)
      access
      |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("access not acked");

  property p_reset_clear;
    @(posedge clk_i)
      rst_i
      |=> raw_status_o == 6'h00 && !irq_o;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left status");

  property p_lane_refuse;
    @(posedge clk_i) disable iff (rst_i)
      access && req.we && req.sel[1:0] != 2'b11 && req.adr == OFS_ICLEAR && raw_status_o[0]
      |=> raw_status_o[0];
  endproperty
  a_lane_refuse: assert property (p_lane_refuse) else $error("partial clear acted");

  property p_rdata_hold;
    @(posedge clk_i) disable iff (rst_i)
      !(access && !req.we)
      |=> $stable(wb_dat_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  property p_tx_set;
    @(posedge clk_i) disable iff (rst_i)
      event_i[1]
      |=> raw_status_o[1];
  endproperty
  a_tx_set: assert property (p_tx_set) else $error("tx event lost");

  property p_be_set;
    @(posedge clk_i) disable iff (rst_i)
      event_i[5]
      |=> raw_status_o[5];
  endproperty
  a_be_set: assert property (p_be_set) else $error("break event lost");

  c_clear: cover property (@(posedge clk_i) clr_wr && |req.dat[9:4]);
  c_irq: cover property (@(posedge clk_i) $rose(irq_o));
  c_id_read: cover property (@(posedge clk_i) access && !req.we && req.adr == OFS_ID4);
  c_collide: cover property (@(posedge clk_i) clr_wr && req.dat[BIT_RX] && event_i[0]);
  c_lane: cover property (@(posedge clk_i) access && req.we && req.sel[1:0] != 2'b11);
endmodule

//--- uic_regs_test.sv
// testbench: wishbone tests of the irq clear bits, enables and identity bytes
`timescale 1ns/10ps
module uic_regs_test;
  import uic_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [ADDR_W-1:0] wb_adr_i = '0;
  logic [31:0] wb_dat_i = '0;
  logic [3:0] wb_sel_i = '0;
  logic [EV_N-1:0] event_i = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [EV_N-1:0] raw_status_o;
  logic [EV_N-1:0] masked_status_o;
  logic irq_o;
  int mismatches = 0;
  int checked = 0;
  logic [5:0] exp_ev;
  logic [31:0] rd_v;
  logic [11:0] id_ofs [6] = '{OFS_ID0, OFS_ID1, OFS_ID4, OFS_ID5, OFS_ID6, OFS_ID7};
  // identity bytes: arbitrary values; the first five are handed to the design below, 0x96 is its ID_BYTE7 default
  logic [7:0] id_val [6] = '{8'h21, 8'h43, 8'h65, 8'h87, 8'hA9, 8'h96};
  logic [3:0] sel_v = 4'hF;

  always #2 clk_i = ~clk_i;

  uic_regs #(.ID_BYTE0(8'h21), .ID_BYTE1(8'h43), .ID_BYTE4(8'h65), .ID_BYTE5(8'h87),
    .ID_BYTE6(8'hA9)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .event_i(event_i), .raw_status_o(raw_status_o), .masked_status_o(masked_status_o),
    .irq_o(irq_o));

  // classic cycle: hold until ack is sampled high, then release for one cycle
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= sel_v;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) begin
      n++;
      @(posedge clk_i);
    end
    rd_v = wb_dat_o;
    chk("ack wait", n, 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic fire(input logic [5:0] m);
    event_i <= m;
    @(posedge clk_i);
    event_i <= '0;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    test_done();
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("raw", {26'h0, raw_status_o}, 32'h0);
    chk("irq", {31'h0, irq_o}, 32'h0);
    bus(OFS_ENABLE, 1'b1, 32'h0000_03F0);
    fire(6'h3F);
    bus(OFS_ICLEAR, 1'b1, 32'h0);
    exp_ev = 6'h3F;
    chk("raw", {26'h0, raw_status_o}, 32'h3F);
    chk("irq", {31'h0, irq_o}, 32'h1);
    // clear one event at a time, the rest must stay set
    for (int i = 0; i < EV_N; i++) begin
      bus(OFS_ICLEAR, 1'b1, 32'h10 << i);
      exp_ev[i] = 1'b0;
      chk("raw", {26'h0, raw_status_o}, {26'h0, exp_ev});
      chk("masked", {26'h0, masked_status_o}, {26'h0, exp_ev});
    end
    chk("irq", {31'h0, irq_o}, 32'h0);
    bus(OFS_ICLEAR, 1'b0, 32'h0);
    chk("clear rd", rd_v, 32'h0);
    $display("test clear bits done");
    bus(OFS_ENABLE, 1'b1, 32'h0000_0010);
    fire(6'h3F);
    chk("masked", {26'h0, masked_status_o}, 32'h1);
    chk("irq", {31'h0, irq_o}, 32'h1);
    bus(OFS_ICLEAR, 1'b1, 32'h0000_0010);
    chk("irq", {31'h0, irq_o}, 32'h0);
    chk("raw", {26'h0, raw_status_o}, 32'h3E);
    $display("test masking done");
    for (int i = 0; i < 6; i++) begin
      bus(id_ofs[i], 1'b0, 32'h0);
      chk("ident", rd_v, {24'h0, id_val[i]});
      bus(id_ofs[i], 1'b1, 32'hFFFF_FFFF);
      bus(id_ofs[i], 1'b0, 32'h0);
      chk("ident", rd_v, {24'h0, id_val[i]});
    end
    bus(12'hF00, 1'b0, 32'h0);
    chk("unmapped", rd_v, 32'h0);
    $display("test identity done");
    bus(OFS_ENABLE, 1'b1, 32'h0000_03F0);
    // one lane only: the clear must be refused
    sel_v = 4'h1;
    bus(OFS_ICLEAR, 1'b1, 32'h0000_03F0);
    sel_v = 4'hF;
    chk("lane", {26'h0, raw_status_o}, 32'h3E);
    // rx event in the very cycle of its clear
    event_i <= 6'h01;
    fork
      begin
        @(posedge clk_i);
        event_i <= '0;
      end
    join_none
    bus(OFS_ICLEAR, 1'b1, 32'h0000_03F0);
    chk("collide", {26'h0, raw_status_o}, 32'h1);
    chk("irq", {31'h0, irq_o}, 32'h1);
    $display("test lanes done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("raw", {26'h0, raw_status_o}, 32'h0);
    chk("irq", {31'h0, irq_o}, 32'h0);
    bus(OFS_ENABLE, 1'b0, 32'h0);
    chk("enable rst", rd_v, 32'h0);
    fire(6'h3F);
    chk("masked", {26'h0, masked_status_o}, 32'h0);
    chk("raw", {26'h0, raw_status_o}, 32'h3F);
    $display("test reset done");
    test_done();
  end
endmodule
